// file: hdl/ssl_device.sv
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module ssl_device (
	input wire logic clk,
	input wire logic reset,
	ssl_serial_if.dev link,
	input wire logic phase_ok,
	output logic [23:0] control_word,
	output logic [23:0] ncount_word,
	output logic [23:0] ref_word,
	output logic [23:0] test_word,
	output logic [13:0] ref_divide_ratio,
	output logic [1:0] antibacklash_width,
	output logic lock_precision_sel,
	output logic factory_test_bit,
	output logic test_mode_active,
	output logic ref_tick,
	output logic band_clk_tick,
	output logic locked
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic sclk_d;
		logic strobe_d;
		logic [ssl_pkg::WORD_W-1:0] shift;
		logic [ssl_pkg::WORD_W-1:0] ctl;
		logic [ssl_pkg::WORD_W-1:0] ncnt;
		logic [ssl_pkg::WORD_W-1:0] rdiv;
		logic [ssl_pkg::WORD_W-1:0] tst;
		logic [ssl_pkg::RATIO_W-1:0] rcnt;
		logic rtick;
		logic [2:0] bcnt;
		logic btick;
		logic [2:0] good;
		logic lock;
	} ssl_dev_s;

	ssl_dev_s st_r;
	ssl_dev_s st_nxt;

	function automatic logic [2:0] band_limit(input logic [1:0] sel);
		band_limit = (3'h1 << sel) - 3'h1;
	endfunction

	// divide ratio field of a reference-divider word
	function automatic logic [ssl_pkg::RATIO_W-1:0] ratio_of(
		input logic [ssl_pkg::WORD_W-1:0] w);
		ratio_of = w[ssl_pkg::RATIO_POS +: ssl_pkg::RATIO_W];
	endfunction

	// good reference cycles needed before lock is declared
	function automatic logic [2:0] lock_need(input logic precise);
		if (precise) begin
			lock_need = ssl_pkg::LOCK_CYC_PRECISE;
		end else begin
			lock_need = ssl_pkg::LOCK_CYC_COARSE;
		end
	endfunction

	logic [13:0] ratio;
	logic [2:0] need;
	logic [ssl_pkg::WORD_W-1:0] word;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.sclk_d = link.sclk;
		st_nxt.strobe_d = link.load_strobe;
		st_nxt.rtick = 1'b0;
		st_nxt.btick = 1'b0;
		ratio = ratio_of(st_r.rdiv);
		need = lock_need(st_r.rdiv[ssl_pkg::LOCK_PREC_POS]);
		word = st_r.shift;

		// --------------------------------------------------
		// input shift register
		// --------------------------------------------------
		// keeps working during power-down
		if (link.sclk && !st_r.sclk_d) begin
			st_nxt.shift = {st_r.shift[ssl_pkg::WORD_W-2:0], link.sdata};
		end

		// --------------------------------------------------
		// latch transfer on the strobe's rising edge
		// --------------------------------------------------
		if (link.load_strobe && !st_r.strobe_d) begin
			case (word[ssl_pkg::ADDR_HI_POS:ssl_pkg::ADDR_LO_POS])
				ssl_pkg::ADDR_CONTROL: begin
					st_nxt.ctl = word;
				end
				ssl_pkg::ADDR_REFDIV: begin
					st_nxt.rdiv = word;
				end
				ssl_pkg::ADDR_NCOUNT: begin
					st_nxt.ncnt = word;
				end
				default: begin
					// stored, but only acted on with the factory bit set
					st_nxt.tst = word;
				end
			endcase
		end

		// --------------------------------------------------
		// reference divider
		// --------------------------------------------------
		// held in its load state while powered down or unprogrammed
		if (!link.chip_power_en || ratio == 14'h0000) begin
			st_nxt.rcnt = 14'h0000;
			st_nxt.bcnt = 3'h0;
			st_nxt.good = 3'h0;
			st_nxt.lock = 1'b0;
		end else begin
			if (st_r.rcnt >= ratio - 14'h0001) begin
				st_nxt.rcnt = 14'h0000;
				st_nxt.rtick = 1'b1;
			end else begin
				st_nxt.rcnt = st_r.rcnt + 14'h0001;
			end
		end

		// --------------------------------------------------
		// band-select clock and lock detect
		// --------------------------------------------------
		if (st_r.rtick) begin
			if (st_r.bcnt >= band_limit(
				st_r.rdiv[ssl_pkg::BSC_POS +: ssl_pkg::BSC_W])) begin
				st_nxt.bcnt = 3'h0;
				st_nxt.btick = 1'b1;
			end else begin
				st_nxt.bcnt = st_r.bcnt + 3'h1;
			end
			// consecutive good reference cycles
			if (!phase_ok) begin
				st_nxt.good = 3'h0;
				st_nxt.lock = 1'b0;
			end else begin
				if (st_r.good < ssl_pkg::LOCK_CYC_PRECISE) begin
					st_nxt.good = st_r.good + 3'h1;
				end
				if (st_r.good + 3'h1 >= need) begin
					st_nxt.lock = 1'b1;
				end
			end
		end

		// no tick leaves a powered-down divider
		if (!link.chip_power_en) begin
			st_nxt.btick = 1'b0;
			st_nxt.rtick = 1'b0;
		end

		// --------------------------------------------------
		// synchronous reset
		// --------------------------------------------------
		if (reset) begin
			st_nxt = '0;
			// strobe idles high: no false load after reset
			st_nxt.strobe_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign control_word = st_r.ctl;
	assign ncount_word = st_r.ncnt;
	assign ref_word = st_r.rdiv;
	assign test_word = st_r.tst;

	// ---------------------------------------------------------------
	// decoded reference-divider fields
	// ---------------------------------------------------------------
	assign ref_divide_ratio = ratio_of(st_r.rdiv);
	assign antibacklash_width = st_r.rdiv[ssl_pkg::ABP_POS +: ssl_pkg::ABP_W];
	assign lock_precision_sel = st_r.rdiv[ssl_pkg::LOCK_PREC_POS];
	assign factory_test_bit = st_r.rdiv[ssl_pkg::FTEST_POS];
	// test latch only takes effect with the factory bit set
	assign test_mode_active = st_r.rdiv[ssl_pkg::FTEST_POS];
	assign ref_tick = st_r.rtick;
	assign band_clk_tick = st_r.btick;
	assign locked = st_r.lock;
	// no readback path exists: the status pin only shows lock
	assign link.multiplexed_status_out = st_r.lock;
endmodule

// file: hdl/ssl_host.sv
`timescale 1ns/1ps
module ssl_host (
	input wire logic clk,
	input wire logic reset,
	ssl_serial_if.host link,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	typedef enum {
		SSL_IDLE,
		SSL_LOW,
		SSL_HIGH,
		SSL_DONE
	} ssl_phase_e;

	typedef struct packed {
		ssl_phase_e phase;
		logic ack;
		logic [31:0] rdata;
		logic [23:0] word;
		logic [4:0] bits;
		logic [2:0] half;
		logic sclk;
		logic sdata;
		logic strobe;
		logic pwr;
		logic lock_q;
	} ssl_host_s;

	ssl_host_s st_r;
	ssl_host_s st_nxt;
	logic busy;
	logic req;
	logic blocked;

	assign busy = (st_r.phase != SSL_IDLE);
	assign req = avs_read || avs_write;
	// a new word waits until the previous frame has finished
	assign blocked = avs_write && avs_address == ssl_pkg::REG_DATA && busy;
	assign avs_waitrequest = req && !st_r.ack;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = req && !st_r.ack && !blocked;
		st_nxt.lock_q = link.multiplexed_status_out;
		if (avs_read && !st_r.ack) begin
			case (avs_address)
				ssl_pkg::REG_STATUS: begin
					st_nxt.rdata = 32'h0;
					st_nxt.rdata[ssl_pkg::ST_BUSY_POS] = busy;
					st_nxt.rdata[ssl_pkg::ST_LOCK_POS] = st_r.lock_q;
				end
				ssl_pkg::REG_CTRL: begin
					st_nxt.rdata = {31'h0, st_r.pwr};
				end
				default: begin
					st_nxt.rdata = 32'h0;
				end
			endcase
		end
		if (avs_write && st_r.ack) begin
			if (avs_address == ssl_pkg::REG_CTRL) begin
				st_nxt.pwr = avs_writedata[ssl_pkg::CTRL_PWR_POS];
			end
		end

		case (st_r.phase)
			SSL_IDLE: begin
				if (avs_write && st_r.ack &&
					avs_address == ssl_pkg::REG_DATA) begin
					st_nxt.word = avs_writedata[23:0];
					// the factory bit only exists in the reference word
					if (avs_writedata[1:0] == ssl_pkg::ADDR_REFDIV) begin
						st_nxt.word[ssl_pkg::FTEST_POS] = 1'b0;
						st_nxt.word[ssl_pkg::RSVD_POS +: ssl_pkg::RSVD_W] =
							2'h0;
					end
					st_nxt.strobe = 1'b0;
					// first bit comes from the forced word
					st_nxt.sdata = st_nxt.word[23];
					st_nxt.bits = 5'h0;
					st_nxt.half = 3'h0;
					st_nxt.phase = SSL_LOW;
				end
			end
			SSL_LOW: begin
				// data was set while the clock was low
				if (st_r.half == 3'(ssl_pkg::SCLK_HALF_CYC - 1)) begin
					st_nxt.half = 3'h0;
					st_nxt.sclk = 1'b1;
					st_nxt.phase = SSL_HIGH;
				end else begin
					st_nxt.half = st_r.half + 3'h1;
				end
			end
			SSL_HIGH: begin
				if (st_r.half == 3'(ssl_pkg::SCLK_HALF_CYC - 1)) begin
					st_nxt.half = 3'h0;
					st_nxt.sclk = 1'b0;
					st_nxt.word = {st_r.word[22:0], 1'b0};
					st_nxt.sdata = st_r.word[22];
					st_nxt.bits = st_r.bits + 5'h1;
					if (st_r.bits == 5'(ssl_pkg::WORD_W - 1)) begin
						st_nxt.phase = SSL_DONE;
					end else begin
						st_nxt.phase = SSL_LOW;
					end
				end else begin
					st_nxt.half = st_r.half + 3'h1;
				end
			end
			SSL_DONE: begin
				st_nxt.strobe = 1'b1;
				st_nxt.sdata = 1'b0;
				st_nxt.phase = SSL_IDLE;
			end
			default: begin
				st_nxt.phase = SSL_IDLE;
			end
		endcase

		if (reset) begin
			st_nxt = '0;
			st_nxt.phase = SSL_IDLE;
			st_nxt.strobe = 1'b1;
			st_nxt.pwr = ssl_pkg::CTRL_PWR_RESET;
		end
	end

	always_ff @(posedge clk) begin
		st_r <= st_nxt;
	end

	assign avs_readdata = st_r.rdata;
	assign link.sclk = st_r.sclk;
	assign link.sdata = st_r.sdata;
	assign link.load_strobe = st_r.strobe;
	assign link.chip_power_en = st_r.pwr;
endmodule

// file: hdl/ssl_pkg.sv
package ssl_pkg;
	// ---------------------------------------------------------------
	// serial word layout
	// ---------------------------------------------------------------
	localparam int WORD_W = 24;
	localparam int ADDR_LO_POS = 0;
	localparam int ADDR_HI_POS = 1;
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_REFDIV = 2'h1;
	localparam logic [1:0] ADDR_NCOUNT = 2'h2;
	localparam logic [1:0] ADDR_TEST = 2'h3;
	// ---------------------------------------------------------------
	// reference-divider latch fields
	// ---------------------------------------------------------------
	localparam int RATIO_POS = 2;
	localparam int RATIO_W = 14;
	localparam int ABP_POS = 16;
	localparam int ABP_W = 2;
	localparam int LOCK_PREC_POS = 18;
	localparam int FTEST_POS = 19;
	localparam int BSC_POS = 20;
	localparam int BSC_W = 2;
	localparam int RSVD_POS = 22;
	localparam int RSVD_W = 2;
	localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;
	localparam logic [2:0] LOCK_CYC_PRECISE = 3'h5;
	localparam logic [2:0] LOCK_CYC_COARSE = 3'h3;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_MIN_PERIOD_NS = 50;
	localparam int SCLK_HALF_CYC =
		(SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ---------------------------------------------------------------
	// host controller registers (avalon-mm byte addresses)
	// ---------------------------------------------------------------
	localparam int AV_ADDR_W = 4;
	localparam logic [3:0] REG_DATA = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	localparam int ST_BUSY_POS = 0;
	localparam int ST_LOCK_POS = 1;
	localparam int CTRL_PWR_POS = 0;
	localparam logic CTRL_PWR_RESET = 1'b1;
endpackage

// file: hdl/ssl_serial_if.sv
`timescale 1ns/1ps
interface ssl_serial_if;
	logic sclk;
	logic sdata;
	logic load_strobe;
	logic chip_power_en;
	logic multiplexed_status_out;
	modport dev (
		input sclk,
		input sdata,
		input load_strobe,
		input chip_power_en,
		output multiplexed_status_out
	);
	modport host (
		output sclk,
		output sdata,
		output load_strobe,
		output chip_power_en,
		input multiplexed_status_out
	);
endinterface

// file: verification/ssl_monitor.sv
`timescale 1ns/1ps
module ssl_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic load_strobe,
	input wire logic chip_power_en,
	input wire logic multiplexed_status_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	logic sclk_r;
	logic [4:0] cnt_r;
	// ------------------------------------------------
	// rising serial clocks counted within one frame
	// ------------------------------------------------
	always_ff @(posedge clk) begin
		sclk_r <= sclk;
		if (reset || load_strobe)
			cnt_r <= 5'h0;
		else if (sclk && !sclk_r)
			cnt_r <= cnt_r + 5'h1;
	end
	frame_len_a:
		assert property ($rose(load_strobe) |-> cnt_r == 5'h18)
		else $error("frame length wrong");
	strobe_fall_a:
		assert property ($fell(load_strobe) |-> !sclk && cnt_r == 5'h0)
		else $error("frame opened badly");
	idle_clk_a:
		assert property (load_strobe |-> !sclk)
		else $error("clock outside frame");
	high_time_a:
		assert property ($rose(sclk) |-> sclk [*3] ##1 !sclk)
		else $error("clock high time wrong");
	low_time_a:
		assert property ($fell(sclk) |-> !sclk [*3])
		else $error("clock low time short");
	data_hold_a:
		assert property (sclk && $past(sclk) |-> $stable(sdata))
		else $error("data moved while clock high");
	sclk_frame_a:
		assert property ($rose(sclk) |-> !load_strobe [*4])
		else $error("strobe rose mid bit");
	lock_off_a:
		assert property (!chip_power_en [*4] |-> !multiplexed_status_out)
		else $error("lock while powered down");
	lock_pwr_a:
		assert property ($rose(multiplexed_status_out) |-> chip_power_en)
		else $error("lock rose unpowered");
	cover property ($rose(load_strobe));
	cover property ($rose(multiplexed_status_out));
	cover property ($fell(chip_power_en));
endmodule

// file: verification/synth_serial_latch_ref_divider_tb.sv
`timescale 1ns/1ps
module synth_serial_latch_ref_divider_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic phase_ok = 1'b0;
	logic [3:0] av_a = 4'h0;
	logic av_rd = 1'b0;
	logic av_wr = 1'b0;
	logic [31:0] av_wd = 32'h0;
	logic [31:0] av_rdat;
	logic av_wait;
	logic [23:0] lw [4];
	logic [13:0] ratio;
	logic [1:0] abw;
	logic lps, ftb, tma, rtick, btick, locked;
	logic [23:0] cap = 24'h0;
	logic [31:0] rd;
	int error_cnt = 0;
	int n_checks = 0;
	ssl_serial_if link ();
	ssl_device ssl_device_inst (.clk(clk), .reset(reset), .link(link.dev),
		.phase_ok(phase_ok), .control_word(lw[0]), .ref_word(lw[1]),
		.ncount_word(lw[2]), .test_word(lw[3]), .ref_divide_ratio(ratio),
		.antibacklash_width(abw), .lock_precision_sel(lps),
		.factory_test_bit(ftb), .test_mode_active(tma), .ref_tick(rtick),
		.band_clk_tick(btick), .locked(locked));
	ssl_host ssl_host_inst (.clk(clk), .reset(reset), .link(link.host),
		.avs_address(av_a), .avs_read(av_rd), .avs_write(av_wr),
		.avs_writedata(av_wd), .avs_readdata(av_rdat),
		.avs_waitrequest(av_wait));
	ssl_monitor ssl_monitor_inst (.clk(clk), .reset(reset),
		.sclk(link.sclk), .sdata(link.sdata),
		.load_strobe(link.load_strobe), .chip_power_en(link.chip_power_en),
		.multiplexed_status_out(link.multiplexed_status_out));
	initial forever #5 clk = ~clk;
	// word as seen on the wire, shifted in at each rising serial clock
	always @(posedge link.sclk) cap <= {cap[22:0], link.sdata};
	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d);
		int i;
		av_a <= a;
		av_wd <= d;
		av_wr <= w;
		av_rd <= !w;
		i = 0;
		do begin
			@(posedge clk);
			i++;
			if (i > 500) begin
				error_cnt++;
				$display("mismatch at %0t: bus timeout", $time);
				results();
			end
		end while (av_wait);
		rd = av_rdat;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic send(input logic [23:0] w, input logic [23:0] e);
		int i;
		av(1'b1, ssl_pkg::REG_DATA, {8'h0, w});
		i = 0;
		do begin
			av(1'b0, ssl_pkg::REG_STATUS, 32'h0);
			i++;
		end while (rd[ssl_pkg::ST_BUSY_POS] && i < 100);
		if (rd[ssl_pkg::ST_BUSY_POS]) begin
			error_cnt++;
			$display("mismatch at %0t: frame timeout", $time);
			results();
		end
		repeat (4) @(posedge clk);
		chk(cap, e);
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic t_reset();
		for (int k = 0; k < 4; k++)
			chk(lw[k], ssl_pkg::LATCH_RESET);
		av(1'b0, ssl_pkg::REG_CTRL, 32'h0);
		chk(rd[0], ssl_pkg::CTRL_PWR_RESET);
		av(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_route();
		logic [23:0] tx [4];
		logic [23:0] ex [4];
		tx = '{24'h123450, 24'hfb000d, 24'hab3de6, 24'h55aa57};
		ex = '{24'h123450, 24'h33000d, 24'hab3de6, 24'h55aa57};
		for (int k = 0; k < 4; k++) begin
			send(tx[k], ex[k]);
			for (int j = 0; j < 4; j++)
				chk(lw[j], j <= k ? ex[j] : 24'h0);
		end
		chk(ratio, 14'h3);
		chk(abw, 2'h3);
		chk({ftb, tma}, 2'h0);
		send(24'h00fffd, 24'h00fffd);
		chk(ratio, 14'h3fff);
	endtask
	task automatic t_lock(input logic p, input int n);
		int k;
		send({5'h0, p, 18'h0000d}, {5'h0, p, 18'h0000d});
		chk(lps, p);
		phase_ok <= 1'b0;
		repeat (8) @(posedge clk);
		chk(link.multiplexed_status_out, 1'b0);
		phase_ok <= 1'b1;
		k = 0;
		for (int i = 0; i < 100 && !locked; i++) begin
			@(posedge clk);
			if (rtick && !locked)
				k++;
		end
		chk(k, n);
		repeat (2) @(posedge clk);
		chk(link.multiplexed_status_out, 1'b1);
		av(1'b0, ssl_pkg::REG_STATUS, 32'h0);
		chk(rd[ssl_pkg::ST_LOCK_POS], 1'b1);
		phase_ok <= 1'b0;
		repeat (8) @(posedge clk);
		chk(locked, 1'b0);
	endtask
	task automatic t_band();
		int c;
		int i;
		for (int f = 0; f < 4; f++) begin
			send({2'h0, f[1:0], 20'h0000d}, {2'h0, f[1:0], 20'h0000d});
			for (i = 0; i < 200 && !btick; i++)
				@(posedge clk);
			c = 0;
			i = 0;
			do begin
				@(posedge clk);
				c += rtick;
			end while (!btick && i++ < 200);
			chk(c, 1 << f);
		end
	endtask
	task automatic t_pwr();
		int c;
		phase_ok <= 1'b1;
		repeat (30) @(posedge clk);
		chk(locked, 1'b1);
		av(1'b1, ssl_pkg::REG_CTRL, 32'h0);
		chk(link.chip_power_en, 1'b0);
		c = 0;
		repeat (20) begin
			@(posedge clk);
			c += rtick;
		end
		chk(c, 0);
		chk(link.multiplexed_status_out, 1'b0);
		av(1'b1, ssl_pkg::REG_CTRL, 32'h1);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_route();
		t_lock(1'b0, ssl_pkg::LOCK_CYC_COARSE);
		t_lock(1'b1, ssl_pkg::LOCK_CYC_PRECISE);
		t_band();
		t_pwr();
		results();
	end
endmodule
